// ==== sph_pkg.sv ====
package sph_pkg;
    localparam int SPH_WIDTH = 8;
    localparam int SPH_CLK_NS = 10;
    localparam int SPH_STOP_NS = 12;
    localparam int SPH_WAKE_US = 1;
    localparam int SPH_STOP_CYC_I = (SPH_STOP_NS / SPH_CLK_NS) < 1 ? 1 : (SPH_STOP_NS / SPH_CLK_NS);
    localparam int SPH_WAKE_CYC_I = (SPH_WAKE_US * 1000) / SPH_CLK_NS;
    localparam logic [7:0] SPH_STOP_CYC = 8'(SPH_STOP_CYC_I);
    localparam logic [7:0] SPH_WAKE_CYC = 8'(SPH_WAKE_CYC_I);
    localparam logic [7:0] SPH_CNT_ZERO = 8'h00;
    localparam logic [7:0] SPH_CNT_ONE = 8'h01;
    localparam logic [SPH_WIDTH-1:0] SPH_DATA_RST = '0;
    typedef enum logic [2:0] {
        SPH_RUN = 3'h1,
        SPH_HOLD = 3'h2,
        SPH_WAKE = 3'h4
    } sph_state_t;
endpackage : sph_pkg

// ==== sph_pins_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface sph_pins_if;
    import sph_pkg::*;
    logic [SPH_WIDTH-1:0] pin_in;
    logic [SPH_WIDTH-1:0] kept;
    logic capture;
    modport keeper (input pin_in, input capture, output kept);
    modport user (output pin_in, output capture, input kept);
endinterface : sph_pins_if
`default_nettype wire

// ==== sph_keeper.sv ====
`timescale 1ns/10ps
`default_nettype none
// per-bit hold latch, implemented as an enabled flop
module sph_keeper
    import sph_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    sph_pins_if.keeper pins
);
    genvar i;
    generate
        for (i = 0; i < SPH_WIDTH; i++) begin : g_bit
            logic kept_q;
            always_ff @(posedge clk) begin
                if (rst) begin
                    kept_q <= 1'b0;
                end else if (pins.capture) begin
                    kept_q <= pins.pin_in[i];
                end
            end
            assign pins.kept[i] = kept_q;
        end
    endgenerate
endmodule : sph_keeper
`default_nettype wire

// ==== sph_hold.sv ====
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - while enabled and sleep pin high, outputs and internal state are frozen.
// - outputs floating at power-down onset stay floating throughout.
// - during power-down all inputs except the sleep pin are ignored.
// - input and bidirectional hold latches keep last levels during power-down.
// - power-down function exists only when the configuration option is set.
// - with option on, sleep pin never reaches the logic array input.
// - device stops responding to inputs within 12 ns after pin rises.
// - device resumes valid operation within 1 us after the pin falls.
module sph_hold
    import sph_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic sleep_enable,
    input wire logic sleep_hold_pin,
    input wire logic [SPH_WIDTH-1:0] data_in,
    input wire logic [SPH_WIDTH-1:0] oe_n_in,
    output logic [SPH_WIDTH-1:0] data_out,
    output logic [SPH_WIDTH-1:0] data_oe_n,
    output logic array_pin_in,
    output logic in_hold,
    output logic ready
);
    sph_state_t state_q, state_d;
    logic [7:0] cnt_q, cnt_d;
    logic opt_q;
    logic [SPH_WIDTH-1:0] out_q, oe_n_q;
    logic arr_q, hold_q, ready_q;

    sph_pins_if pins();

    // option sampled only at reset: a configuration choice, not live
    always_ff @(posedge clk) begin
        if (rst) begin
            opt_q <= sleep_enable;
        end
    end

    wire sleep_req = opt_q & sleep_hold_pin;
    wire running = (state_q == SPH_RUN);
    wire cnt_done = (cnt_q == SPH_CNT_ONE);
    // inputs reach state only while running with no sleep request (pin low or option off)
    wire upd_out = running & ~sleep_req;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            SPH_RUN: begin
                if (sleep_req) begin
                    state_d = SPH_HOLD;
                    cnt_d = SPH_CNT_ZERO;
                end
            end
            SPH_HOLD: begin
                if (!sleep_req) begin
                    state_d = SPH_WAKE;
                    // one short: the pin is seen up to a cycle after it falls
                    cnt_d = SPH_WAKE_CYC - SPH_CNT_ONE;
                end
            end
            SPH_WAKE: begin
                if (sleep_req) begin
                    state_d = SPH_HOLD;
                    cnt_d = SPH_CNT_ZERO;
                end else if (cnt_done) begin
                    state_d = SPH_RUN;
                    cnt_d = SPH_CNT_ZERO;
                end else begin
                    cnt_d = cnt_q - SPH_CNT_ONE;
                end
            end
            default: begin
                state_d = SPH_RUN;
                cnt_d = SPH_CNT_ZERO;
            end
        endcase
    end

    // keeper captures pins only while running; frozen otherwise
    assign pins.pin_in = data_in;
    assign pins.capture = upd_out;

    sph_keeper u_keeper (
        .clk(clk),
        .rst(rst),
        .pins(pins)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= SPH_RUN;
            cnt_q <= SPH_CNT_ZERO;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // outputs, enables and the array input update only when running
    always_ff @(posedge clk) begin
        if (rst) begin
            out_q <= SPH_DATA_RST;
            oe_n_q <= '1;
            arr_q <= 1'b0;
        end else if (upd_out) begin
            out_q <= pins.kept;
            oe_n_q <= oe_n_in;
            arr_q <= opt_q ? 1'b0 : sleep_hold_pin;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hold_q <= 1'b0;
            ready_q <= 1'b0;
        end else begin
            hold_q <= (state_d != SPH_RUN);
            ready_q <= (state_d == SPH_RUN);
        end
    end

    assign data_out = out_q;
    assign data_oe_n = oe_n_q;
    assign array_pin_in = arr_q;
    assign in_hold = hold_q;
    assign ready = ready_q;

    // enables as they stood when the last hold began
    logic [SPH_WIDTH-1:0] onset_oe_n_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            onset_oe_n_q <= '1;
        end else if (running) begin
            onset_oe_n_q <= data_oe_n;
        end
    end

    // own count of held cycles with the pin low, apart from the state counter
    logic [7:0] wake_age_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            wake_age_q <= SPH_CNT_ZERO;
        end else if (in_hold && !sleep_req) begin
            wake_age_q <= wake_age_q + SPH_CNT_ONE;
        end else begin
            wake_age_q <= SPH_CNT_ZERO;
        end
    end

    hold_out_a: assert property (@(posedge clk) disable iff (rst)
        (in_hold && $past(in_hold)) |-> $stable(data_out))
        else $error("output changed while held");
    hold_oe_a: assert property (@(posedge clk) disable iff (rst)
        (in_hold && $past(in_hold)) |-> $stable(data_oe_n))
        else $error("enable changed while held");
    block_in_a: assert property (@(posedge clk) disable iff (rst)
        (!running) |=> $stable(pins.kept))
        else $error("input reached state in hold");
    stop_resp_a: assert property (@(posedge clk) disable iff (rst)
        (sleep_req && running) |-> ##[1:1] in_hold)
        else $error("hold not entered in time");
    wake_time_a: assert property (@(posedge clk) disable iff (rst)
        (state_q == SPH_HOLD && !sleep_req) |-> ##[1:100] (ready || sleep_req))
        else $error("wake took too long");
    no_opt_a: assert property (@(posedge clk) disable iff (rst)
        !opt_q |-> !in_hold)
        else $error("held without option");
    arr_zero_a: assert property (@(posedge clk) disable iff (rst)
        opt_q |=> !array_pin_in)
        else $error("sleep pin leaked to array");
    opt_gate_a: assert property (@(posedge clk) disable iff (rst)
        (sleep_hold_pin && !opt_q) |=> ready)
        else $error("pin acted without option");
    // blocked inputs and frozen pins; freeze_io_a is wider than the held-only checks above
    freeze_io_a: assert property (@(posedge clk) disable iff (rst)
        !upd_out |=> ($stable(data_out) && $stable(data_oe_n)))
        else $error("pins moved while inputs blocked");
    keep_hold_a: assert property (@(posedge clk) disable iff (rst)
        (in_hold && $past(in_hold)) |-> $stable(pins.kept))
        else $error("hold latch moved while held");
    float_keep_a: assert property (@(posedge clk) disable iff (rst)
        in_hold |-> ((onset_oe_n_q & ~data_oe_n) == '0))
        else $error("floating output driven in hold");

    // hold and ready exclusion, hold cause, resume and wake window
    hold_excl_a: assert property (@(posedge clk) disable iff (rst)
        in_hold |-> !ready)
        else $error("ready while held");
    hold_cause_a: assert property (@(posedge clk) disable iff (rst)
        $rose(in_hold) |-> $past(sleep_req))
        else $error("hold entered without the pin");
    resume_cap_a: assert property (@(posedge clk) disable iff (rst)
        $rose(ready) |-> (pins.capture || sleep_req))
        else $error("inputs still blocked after wake");
    wake_age_a: assert property (@(posedge clk) disable iff (rst)
        wake_age_q <= SPH_WAKE_CYC)
        else $error("wake outlasted its window");

    // option guards
    pin_follow_a: assert property (@(posedge clk) disable iff (rst)
        (!opt_q && running) |=> (array_pin_in == $past(sleep_hold_pin)))
        else $error("pin not passed to array without option");
    opt_fixed_a: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> $stable(opt_q))
        else $error("option changed outside reset");
    arr_now_a: assert property (@(posedge clk) disable iff (rst)
        opt_q |-> !array_pin_in)
        else $error("array input high with option on");

    // scenario covers
    c_enter: cover property (@(posedge clk) disable iff (rst) running ##1 in_hold);
    c_wake: cover property (@(posedge clk) disable iff (rst) (state_q == SPH_WAKE) ##1 ready);
    c_rehold: cover property (@(posedge clk) disable iff (rst)
        (state_q == SPH_WAKE) ##1 (state_q == SPH_HOLD));
    c_noopt: cover property (@(posedge clk) disable iff (rst)
        (!opt_q && sleep_hold_pin) ##1 array_pin_in);
    c_long: cover property (@(posedge clk) disable iff (rst) in_hold [*8]);
endmodule : sph_hold
`default_nettype wire

// ==== sph_far.sv ====
`timescale 1ns/10ps
`default_nettype none
// outside logic: settles data a cycle before raising the pin
module sph_far
    import sph_pkg::*;
(
    input wire logic clk,
    input wire logic want_sleep,
    input wire logic [SPH_WIDTH-1:0] want_data,
    output logic sleep_hold_pin = 1'b0,
    output logic [SPH_WIDTH-1:0] data_in = '0
);
    logic req_q = 1'b0;
    logic req2_q = 1'b0;
    logic pin_q = 1'b0;
    logic [SPH_WIDTH-1:0] data_q = '0;
    // requests taken on the rising edge, pins move on the falling edge
    always_ff @(posedge clk) begin
        req_q <= want_sleep;
        req2_q <= req_q;
        data_q <= want_data;
    end
    always_ff @(negedge clk) begin
        // pin rises a cycle after the data last moved, falls at once
        sleep_hold_pin <= req_q & (req2_q | sleep_hold_pin);
        pin_q <= sleep_hold_pin;
        // don't-care inputs only once the pin has stood high past the stop time
        data_in <= pin_q ? ~data_in : data_q;
    end
endmodule : sph_far
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import sph_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sleep_enable = 1'b1;
    logic want_sleep = 1'b0;
    logic [SPH_WIDTH-1:0] oe_n_in = 8'hf0;
    logic [SPH_WIDTH-1:0] want_data = 8'ha5;
    logic [SPH_WIDTH-1:0] data_in, data_out, data_oe_n;
    logic sleep_hold_pin, array_pin_in, in_hold, ready;
    int err_total = 0;
    int n_checks = 0;
    always #5 clk = ~clk;
    sph_far far (.clk(clk), .want_sleep(want_sleep), .want_data(want_data),
        .sleep_hold_pin(sleep_hold_pin), .data_in(data_in));
    sph_hold DUT (.clk(clk), .rst(rst), .sleep_enable(sleep_enable),
        .sleep_hold_pin(sleep_hold_pin), .data_in(data_in), .oe_n_in(oe_n_in),
        .data_out(data_out), .data_oe_n(data_oe_n), .array_pin_in(array_pin_in),
        .in_hold(in_hold), .ready(ready));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_sim;
        if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    // bounded wait; running out is a failure
    task automatic wait_ready(input int lim);
        int k;
        k = 0;
        while (ready !== 1'b1 && k < lim) begin
            cyc(1);
            k++;
        end
        if (ready !== 1'b1) begin
            err_total++;
            end_sim();
        end
    endtask : wait_ready
    task automatic do_reset(input logic opt);
        rst = 1'b1;
        sleep_enable = opt;
        cyc(20);
        rst = 1'b0;
        wait_ready(5);
    endtask : do_reset
    task automatic t_hold;
        cyc(4);
        chk(data_out, 8'ha5);
        chk({7'h0, array_pin_in}, 8'h00);
        want_sleep = 1'b1;
        cyc(3);
        chk({6'h0, in_hold, ready}, 8'h02);
        oe_n_in = 8'h0f;
        want_data = 8'h3c;
        cyc(30);
        chk(data_out, 8'ha5);
        chk(data_oe_n, 8'hf0);
    endtask : t_hold
    task automatic t_wake;
        want_sleep = 1'b0;
        cyc(3);
        chk({7'h0, ready}, 8'h00);
        chk(data_out, 8'ha5);
        wait_ready(98); // bound ends 1 us after the pin fell
        cyc(3);
        chk(data_out, 8'h3c);
        chk(data_oe_n, 8'h0f);
    endtask : t_wake
    task automatic t_noopt;
        do_reset(1'b0);
        want_sleep = 1'b1;
        cyc(3);
        chk({6'h0, in_hold, array_pin_in}, 8'h01);
        chk({7'h0, ready}, 8'h01);
        want_sleep = 1'b0;
        cyc(3);
        chk({7'h0, array_pin_in}, 8'h00);
    endtask : t_noopt
    initial begin
        do_reset(1'b1);
        t_hold();
        t_wake();
        t_noopt();
        end_sim();
    end
endmodule : testbench
`default_nettype wire
